// ### dma_ctrl_pkg.sv
package dma_ctrl_pkg;

	// ----------------------------------------
	// Register offsets, byte addresses on the bus
	// ----------------------------------------
	localparam logic [7:0] OFF_ENABLE_SET = 8'h00;
	localparam logic [7:0] OFF_ENABLE_CLR = 8'h04;
	localparam logic [7:0] OFF_SEC_SET = 8'h08;
	localparam logic [7:0] OFF_DEF_SET = 8'h0C;
	localparam logic [7:0] OFF_SW_REQ = 8'h10;
	localparam logic [7:0] OFF_TABLE_BASE = 8'h14;
	localparam logic [7:0] OFF_STRUCT_INDEX = 8'h18;
	localparam logic [7:0] OFF_STRUCT_CTRL = 8'h1C;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_WIDTH_LSB = 4;
	localparam int CTRL_COUNT_LSB = 16;
	localparam int INDEX_ALT_BIT = 5;
	localparam int TABLE_ALIGN_BITS = 10;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic primary_struct_select = 1'b0;
	localparam logic alternate_struct_select = 1'b1;
	localparam int software_request_channel = 30;

	// ----------------------------------------
	// Transfer modes and item widths
	// ----------------------------------------
	typedef enum logic [2:0] {
		xfer_mode_halted = 3'h0,
		xfer_mode_request_driven = 3'h1,
		xfer_mode_run_to_completion = 3'h2,
		xfer_mode_double_buffer = 3'h3,
		xfer_mode_memory_task_list = 3'h4,
		xfer_mode_memory_task_list_alt = 3'h5,
		xfer_mode_peripheral_task_list = 3'h6,
		xfer_mode_peripheral_task_list_alt = 3'h7
	} xfer_mode_t;

	typedef enum logic [1:0] {
		ITEM_BYTE = 2'h0,
		ITEM_HALF = 2'h1,
		ITEM_WORD = 2'h2,
		ITEM_RSVD = 2'h3
	} item_width_t;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_WAIT = 1'b1
	} bus_state_t;

	typedef struct packed {
		logic alt;
		logic [4:0] chan;
		item_width_t width;
	} move_t;

endpackage

// ### dma_channel_control.sv
// Behaviour
// - Each channel selects default or secondary peripheral; default settable for many at once.
// - With secondary selected, the default peripheral's requests are ignored.
// - Items are 8, 16 or 32 bits, chosen per control structure.
// - Remaining item count is readable, decrements per move, reads zero when done.
// - Length counts items, never bytes.
// - Two structures per channel, picked by channel number plus alternate select.
// - A completed structure gets the halted mode written back.
// - Request-driven mode moves only while the peripheral request is present; a software request runs it until the count ends.
// - Run-to-completion mode finishes once started, even if request drops.
// - Double-buffer mode alternates primary and alternate structures.
// - Task-list mode codes differ between primary and alternate structures.
// - No move until structure configured and channel enabled.
// - Channel enable clears itself on completion.
// - Software can rewrite any structure, active or idle; a finished structure reads halted.
// - Alternate structures occupy the second half of the table.
// - Software channel completes on its own line, others on peripheral lines.
`timescale 1ns/1ps
`default_nettype none

module dma_channel_control #(
	parameter int NUM_CH = 32,
	parameter int COUNT_W = 11
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Peripheral requests
	input wire logic [NUM_CH-1:0] dfltReq,
	input wire logic [NUM_CH-1:0] secReq,
	// Item moves and completion
	output logic moveValid,
	output dma_ctrl_pkg::move_t moveInfo,
	output logic swDoneIrq,
	output logic [NUM_CH-1:0] periphDone
);

	localparam int CH_W = $clog2(NUM_CH);
	localparam int IDX_W = CH_W + 1;
	localparam int NUM_ST = 2 * NUM_CH;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	dma_ctrl_pkg::bus_state_t busState_reg;
	dma_ctrl_pkg::bus_state_t busState_next;
	logic wrPend_reg;
	logic [7:0] offReg_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] readMux;

	wire addrTake = hsel && htrans[1] && hready;
	wire wordOk = (hsize == 3'h2) && (haddr[31:8] == 24'h00_0000);
	wire wrEn = wrPend_reg;
	wire wrEnSet = wrEn && (offReg_reg == dma_ctrl_pkg::OFF_ENABLE_SET);
	wire wrEnClr = wrEn && (offReg_reg == dma_ctrl_pkg::OFF_ENABLE_CLR);
	wire wrSec = wrEn && (offReg_reg == dma_ctrl_pkg::OFF_SEC_SET);
	wire wrDef = wrEn && (offReg_reg == dma_ctrl_pkg::OFF_DEF_SET);
	wire wrSw = wrEn && (offReg_reg == dma_ctrl_pkg::OFF_SW_REQ);
	wire wrBase = wrEn && (offReg_reg == dma_ctrl_pkg::OFF_TABLE_BASE);
	wire wrIdx = wrEn && (offReg_reg == dma_ctrl_pkg::OFF_STRUCT_INDEX);
	wire wrCtrl = wrEn && (offReg_reg == dma_ctrl_pkg::OFF_STRUCT_CTRL);

	// Reads insert one wait state so the returned word is taken after any write of the previous transfer.
	assign busState_next = (busState_reg == dma_ctrl_pkg::BUS_IDLE && addrTake && !hwrite && wordOk)
		? dma_ctrl_pkg::BUS_WAIT : dma_ctrl_pkg::BUS_IDLE;
	assign hreadyout = (busState_reg != dma_ctrl_pkg::BUS_WAIT);
	assign hrdata = hrdata_reg;
	assign hresp = 1'b0;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busState_reg <= dma_ctrl_pkg::BUS_IDLE;
			wrPend_reg <= 1'b0;
			offReg_reg <= 8'h00;
			hrdata_reg <= dma_ctrl_pkg::RST_WORD;
		end else begin
			busState_reg <= busState_next;
			if (hready) begin
				wrPend_reg <= addrTake && hwrite && wordOk;
			end
			if (addrTake) begin
				offReg_reg <= haddr[7:0];
			end
			if (busState_reg == dma_ctrl_pkg::BUS_WAIT) begin
				hrdata_reg <= readMux;
			end
		end
	end

	// ----------------------------------------
	// Channel and structure state
	// ----------------------------------------
	logic [NUM_CH-1:0] enable_reg;
	logic [NUM_CH-1:0] secSel_reg;
	logic [NUM_CH-1:0] running_reg;
	logic [NUM_CH-1:0] activeAlt_reg;
	logic [31:0] tableBase_reg;
	logic [IDX_W-1:0] structIdx_reg;
	dma_ctrl_pkg::xfer_mode_t modeArr_reg [NUM_ST];
	dma_ctrl_pkg::item_width_t widthArr_reg [NUM_ST];
	logic [COUNT_W-1:0] countArr_reg [NUM_ST];
	logic moveValid_reg;
	dma_ctrl_pkg::move_t moveInfo_reg;
	logic [NUM_CH-1:0] done_reg;

	logic [NUM_CH-1:0] chReq;
	logic [NUM_CH-1:0] ready;
	logic [NUM_CH-1:0] basicCh;
	logic pickHit;
	logic [CH_W-1:0] pick;

	// Alternate select is the top index bit, so alternates fill the upper half of the table.
	wire [IDX_W-1:0] wIdx = {hwdata[dma_ctrl_pkg::INDEX_ALT_BIT], hwdata[CH_W-1:0]};
	wire [2:0] wModeRaw = hwdata[dma_ctrl_pkg::CTRL_MODE_LSB +: 3];
	wire wAlt = structIdx_reg[CH_W];
	wire wTaskList = wModeRaw[2];
	// Task-list codes are stored with the structure's own variant.
	wire [2:0] wModeMap = wTaskList ? {wModeRaw[2:1], wAlt} : wModeRaw;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		wire [IDX_W-1:0] curIdx = {activeAlt_reg[c], CH_W'(c)};
		// A channel on its secondary peripheral no longer sees its default one.
		assign chReq[c] = secSel_reg[c] ? secReq[c] : dfltReq[c];
		assign basicCh[c] = (modeArr_reg[curIdx] == dma_ctrl_pkg::xfer_mode_request_driven);
		assign ready[c] = enable_reg[c] && (modeArr_reg[curIdx] != dma_ctrl_pkg::xfer_mode_halted)
			&& (countArr_reg[curIdx] != '0) && (chReq[c] || running_reg[c]);
	end

	// Lowest numbered ready channel moves one item per cycle.
	always_comb begin
		pickHit = 1'b0;
		pick = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (ready[i]) begin
				pickHit = 1'b1;
				pick = CH_W'(i);
			end
		end
	end

	wire selAlt = activeAlt_reg[pick];
	wire [IDX_W-1:0] selIdx = {selAlt, pick};
	wire [IDX_W-1:0] otherIdx = {~selAlt, pick};
	dma_ctrl_pkg::xfer_mode_t selMode;
	dma_ctrl_pkg::item_width_t selWidth;
	logic [COUNT_W-1:0] selCnt;
	assign selMode = modeArr_reg[selIdx];
	assign selWidth = widthArr_reg[selIdx];
	assign selCnt = countArr_reg[selIdx];
	wire moveGo = pickHit;
	wire selLast = (selCnt == COUNT_W'(1));
	wire selAlternating = (selMode == dma_ctrl_pkg::xfer_mode_double_buffer) || selMode[2];
	wire swapOk = selAlternating && (modeArr_reg[otherIdx] != dma_ctrl_pkg::xfer_mode_halted);
	wire finish = moveGo && selLast && !swapOk;
	wire [NUM_CH-1:0] pickOneHot = NUM_CH'(1) << pick;
	wire [NUM_CH-1:0] lastVec = (moveGo && selLast) ? pickOneHot : '0;
	wire [NUM_CH-1:0] doneVec = finish ? pickOneHot : '0;
	wire [NUM_CH-1:0] swSet = wrSw ? hwdata[NUM_CH-1:0] : '0;
	wire [NUM_CH-1:0] enSet = wrEnSet ? hwdata[NUM_CH-1:0] : '0;
	wire [NUM_CH-1:0] enClr = wrEnClr ? hwdata[NUM_CH-1:0] : '0;
	wire [NUM_CH-1:0] secSet = wrSec ? hwdata[NUM_CH-1:0] : '0;
	wire [NUM_CH-1:0] defSet = wrDef ? hwdata[NUM_CH-1:0] : '0;
	// A request still high on the last item must not arm the channel's next transfer.
	wire [NUM_CH-1:0] runSet = swSet | (chReq & enable_reg & ~basicCh & ~lastVec);

	// Software enabling in the completing cycle keeps the channel enabled.
	wire [NUM_CH-1:0] enable_next = (enable_reg & ~enClr & ~doneVec) | enSet;
	wire [NUM_CH-1:0] secSel_next = (secSel_reg | secSet) & ~defSet;
	// Auto mode latches the start and ignores a dropped request until the count ends.
	wire [NUM_CH-1:0] running_next = (running_reg & ~lastVec) | runSet;
	wire [NUM_CH-1:0] activeAlt_next = (moveGo && selLast && swapOk) ? (activeAlt_reg ^ pickOneHot)
		: activeAlt_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= '0;
			secSel_reg <= '0;
			running_reg <= '0;
			activeAlt_reg <= '0;
			tableBase_reg <= dma_ctrl_pkg::RST_WORD;
			structIdx_reg <= '0;
			moveValid_reg <= 1'b0;
			moveInfo_reg <= '0;
			done_reg <= '0;
		end else begin
			enable_reg <= enable_next;
			secSel_reg <= secSel_next;
			running_reg <= running_next;
			activeAlt_reg <= activeAlt_next;
			if (wrBase) begin
				tableBase_reg <= {hwdata[31:dma_ctrl_pkg::TABLE_ALIGN_BITS], dma_ctrl_pkg::TABLE_ALIGN_BITS'(0)};
			end
			if (wrIdx) begin
				structIdx_reg <= wIdx;
			end
			moveValid_reg <= moveGo;
			moveInfo_reg <= moveGo ? {selAlt, 5'(pick), selWidth} : moveInfo_reg;
			done_reg <= doneVec;
		end
	end

	// Hardware updates follow the software write, so the engine's count decrement and halted write win on the same structure.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_ST; i++) begin
				modeArr_reg[i] <= dma_ctrl_pkg::xfer_mode_halted;
				widthArr_reg[i] <= dma_ctrl_pkg::ITEM_BYTE;
				countArr_reg[i] <= '0;
			end
		end else begin
			if (wrCtrl) begin
				modeArr_reg[structIdx_reg] <= dma_ctrl_pkg::xfer_mode_t'(wModeMap);
				widthArr_reg[structIdx_reg] <= dma_ctrl_pkg::item_width_t'(hwdata[dma_ctrl_pkg::CTRL_WIDTH_LSB +: 2]);
				countArr_reg[structIdx_reg] <= hwdata[dma_ctrl_pkg::CTRL_COUNT_LSB +: COUNT_W];
			end
			if (moveGo) begin
				countArr_reg[selIdx] <= selCnt - COUNT_W'(1);
				if (selLast) begin
					modeArr_reg[selIdx] <= dma_ctrl_pkg::xfer_mode_halted;
				end
			end
		end
	end

	// ----------------------------------------
	// Read back and outputs
	// ----------------------------------------
	wire [31:0] ctrlWord = (32'(countArr_reg[structIdx_reg]) << dma_ctrl_pkg::CTRL_COUNT_LSB)
		| (32'(widthArr_reg[structIdx_reg]) << dma_ctrl_pkg::CTRL_WIDTH_LSB)
		| (32'(modeArr_reg[structIdx_reg]) << dma_ctrl_pkg::CTRL_MODE_LSB);
	wire [31:0] idxWord = (32'(structIdx_reg[CH_W]) << dma_ctrl_pkg::INDEX_ALT_BIT)
		| 32'(structIdx_reg[CH_W-1:0]);
	wire [7:0] rdOff = offReg_reg;
	assign readMux = (rdOff == dma_ctrl_pkg::OFF_ENABLE_SET) ? 32'(enable_reg)
		: (rdOff == dma_ctrl_pkg::OFF_SEC_SET) ? 32'(secSel_reg)
		: (rdOff == dma_ctrl_pkg::OFF_TABLE_BASE) ? tableBase_reg
		: (rdOff == dma_ctrl_pkg::OFF_STRUCT_INDEX) ? idxWord
		: (rdOff == dma_ctrl_pkg::OFF_STRUCT_CTRL) ? ctrlWord
		: 32'h0000_0000;

	assign moveValid = moveValid_reg;
	assign moveInfo = moveInfo_reg;
	// The software channel signals on its own line and is masked from the peripheral lines.
	assign swDoneIrq = done_reg[dma_ctrl_pkg::software_request_channel];
	assign periphDone = done_reg & ~(NUM_CH'(1) << dma_ctrl_pkg::software_request_channel);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_move_when_enabled: assert property (@(posedge ref_clk) disable iff (!rst_n)
		moveGo |-> enable_reg[pick] && (selMode != dma_ctrl_pkg::xfer_mode_halted))
		else $error("Item moved on a disabled or halted channel.");

	a_basic_needs_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
		moveGo && (selMode == dma_ctrl_pkg::xfer_mode_request_driven) |-> chReq[pick] || running_reg[pick])
		else $error("Request-driven move without a request.");

	a_sec_blocks_dflt: assert property (@(posedge ref_clk) disable iff (!rst_n)
		moveGo && secSel_reg[pick] && !secReq[pick] |-> running_reg[pick])
		else $error("Default peripheral request served on a secondary channel.");

	a_count_decrement: assert property (@(posedge ref_clk) disable iff (!rst_n)
		moveGo && !wrCtrl |=> countArr_reg[$past(selIdx)] == $past(selCnt) - COUNT_W'(1))
		else $error("Remaining count did not drop by one item.");

	a_done_halts_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
		moveGo && selLast |=> modeArr_reg[$past(selIdx)] == dma_ctrl_pkg::xfer_mode_halted)
		else $error("Completed structure not set to halted.");

	a_done_disables: assert property (@(posedge ref_clk) disable iff (!rst_n)
		finish && !enSet[pick] |=> !enable_reg[$past(pick)] ##1 !moveValid || moveInfo.chan != 5'($past(pick, 2)))
		else $error("Channel still enabled after completion.");

	a_swap_structure: assert property (@(posedge ref_clk) disable iff (!rst_n)
		moveGo && selLast && swapOk |=> activeAlt_reg[$past(pick)] != $past(selAlt) && enable_reg[$past(pick)])
		else $error("Double-buffer channel failed to swap structures.");

	a_move_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
		moveGo |=> moveValid && moveInfo.width == $past(selWidth) && moveInfo.alt == $past(selAlt))
		else $error("Move width or structure mismatch.");

	a_sw_done_line: assert property (@(posedge ref_clk) disable iff (!rst_n)
		finish && (32'(pick) == dma_ctrl_pkg::software_request_channel) |=> swDoneIrq && periphDone == '0)
		else $error("Software channel completion not on its own line.");

	a_read_one_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
		busState_reg == dma_ctrl_pkg::BUS_IDLE && addrTake && !hwrite && wordOk |=> !hreadyout ##1 hreadyout)
		else $error("Read did not complete after one wait state.");

endmodule

`default_nettype wire

// ### periph_req_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Peripheral request lines
// ----------------------------------------
// Requests are registered, as a real peripheral's flop would be, so the block never
// sees a level that changes within the cycle the bench changed it.
module periph_req_model #(
	parameter int NUM_CH = 32
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Commanded levels
	input wire logic [NUM_CH-1:0] dfltCmd,
	input wire logic [NUM_CH-1:0] secCmd,
	// Request lines
	output logic [NUM_CH-1:0] dfltReq,
	output logic [NUM_CH-1:0] secReq
);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dfltReq <= '0;
			secReq <= '0;
		end else begin
			dfltReq <= dfltCmd;
			secReq <= secCmd;
		end
	end
endmodule

`default_nettype wire

// ### dma_channel_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module dma_channel_control_test;
	logic ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, dCmd = 0, sCmd = 0, doneMask = 0, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, moveValid, swDoneIrq;
	logic [31:0] hrdata, dfltReq, secReq, periphDone;
	dma_ctrl_pkg::move_t moveInfo, lastInfo;
	int bad_count = 0, compares = 0, moveCount = 0, swDone = 0, m;

	initial forever #2.5 ref_clk = ~ref_clk;

	dma_channel_control i_dma_channel_control (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dfltReq(dfltReq), .secReq(secReq),
		.moveValid(moveValid), .moveInfo(moveInfo), .swDoneIrq(swDoneIrq), .periphDone(periphDone));
	periph_req_model i_periph_req_model (.ref_clk(ref_clk), .rst_n(rst_n), .dfltCmd(dCmd), .secCmd(sCmd),
		.dfltReq(dfltReq), .secReq(secReq));

	always @(posedge ref_clk) begin
		if (moveValid === 1'b1) begin
			moveCount++;
			lastInfo = moveInfo;
		end
		doneMask |= periphDone;
		if (swDoneIrq === 1'b1) swDone++;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task print_verdict;
		if (bad_count == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// The bus's hready is the slave's own hreadyout, so both phases wait on it.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge ref_clk);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		n = 0;
		do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			bad_count++;
			print_verdict;
		end
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		n = 0;
		do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		r = hrdata;
		if (hreadyout !== 1'b1) begin
			bad_count++;
			print_verdict;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1, a, d, r);
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(0, a, 0, rd);
		chk(nm, rd, exp);
		chk("hresp", {31'h0, hresp}, 0);
	endtask

	task automatic setup(input int ch, input logic alt, input logic [2:0] md, input logic [1:0] w, input int cnt);
		wr(dma_ctrl_pkg::OFF_STRUCT_INDEX, {26'h0, alt, ch[4:0]});
		wr(dma_ctrl_pkg::OFF_STRUCT_CTRL, {5'h0, cnt[10:0], 10'h0, w, 1'b0, md});
		moveCount = 0;
		doneMask = 0;
	endtask

	task automatic wait_moves(input int n);
		int k;
		for (k = 0; k < 400 && moveCount < n; k++) @(posedge ref_clk);
		if (moveCount < n) begin
			bad_count++;
			print_verdict;
		end
		repeat (3) @(posedge ref_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		rdchk("enable", dma_ctrl_pkg::OFF_ENABLE_SET, 0);
		rdchk("select", dma_ctrl_pkg::OFF_SEC_SET, 0);
		rdchk("ctrl", dma_ctrl_pkg::OFF_STRUCT_CTRL, 0);
		rdchk("unmapped", 8'h40, 0);
		wr(dma_ctrl_pkg::OFF_TABLE_BASE, 32'h2000_0400);
		rdchk("table base", dma_ctrl_pkg::OFF_TABLE_BASE, 32'h2000_0400);
	endtask

	task t_basic;
		setup(2, 0, 3'h1, 2'h1, 8);
		dCmd[2] <= 1;
		repeat (8) @(posedge ref_clk);
		chk("moves before enable", moveCount, 0);
		wr(dma_ctrl_pkg::OFF_ENABLE_SET, 32'h0000_0004);
		wait_moves(1);
		dCmd[2] <= 0;
		repeat (10) @(posedge ref_clk);
		m = moveCount;
		chk("paused", m < 8, 1);
		rdchk("remaining", dma_ctrl_pkg::OFF_STRUCT_CTRL, ((8 - m) << 16) | 32'h11);
		dCmd[2] <= 1;
		wait_moves(8);
		dCmd[2] <= 0;
		chk("move info", lastInfo, {1'b0, 5'h02, 2'h1});
		chk("done ch2", doneMask[2], 1);
		rdchk("auto disable", dma_ctrl_pkg::OFF_ENABLE_SET, 0);
		rdchk("finished", dma_ctrl_pkg::OFF_STRUCT_CTRL, 32'h10);
	endtask

	task t_select;
		wr(dma_ctrl_pkg::OFF_SEC_SET, 32'h0000_0008);
		rdchk("secondary", dma_ctrl_pkg::OFF_SEC_SET, 32'h8);
		setup(3, 0, 3'h1, 2'h0, 12);
		wr(dma_ctrl_pkg::OFF_ENABLE_SET, 32'h0000_0008);
		dCmd[3] <= 1;
		repeat (10) @(posedge ref_clk);
		chk("default ignored", moveCount, 0);
		sCmd[3] <= 1;
		wait_moves(1);
		sCmd[3] <= 0;
		repeat (4) @(posedge ref_clk);
		m = moveCount;
		repeat (4) @(posedge ref_clk);
		chk("secondary paused", moveCount, m);
		chk("items left", m < 12, 1);
		wr(dma_ctrl_pkg::OFF_DEF_SET, 32'h0000_0008);
		rdchk("default again", dma_ctrl_pkg::OFF_SEC_SET, 0);
		wait_moves(12);
		dCmd[3] <= 0;
		chk("done ch3", doneMask[3], 1);
	endtask

	task t_auto;
		setup(4, 0, 3'h2, 2'h2, 4);
		wr(dma_ctrl_pkg::OFF_ENABLE_SET, 32'h0000_0010);
		dCmd[4] <= 1;
		@(posedge ref_clk);
		dCmd[4] <= 0;
		wait_moves(4);
		chk("run through", moveCount, 4);
		chk("done ch4", doneMask[4], 1);
		dCmd[4] <= 1;
		setup(4, 0, 3'h2, 2'h2, 2);
		wr(dma_ctrl_pkg::OFF_ENABLE_SET, 32'h0000_0010);
		wait_moves(2);
		dCmd[4] <= 0;
		setup(4, 0, 3'h1, 2'h2, 2);
		wr(dma_ctrl_pkg::OFF_ENABLE_SET, 32'h0000_0010);
		repeat (10) @(posedge ref_clk);
		chk("no stale start", moveCount, 0);
		wr(dma_ctrl_pkg::OFF_ENABLE_CLR, 32'h0000_0010);
		rdchk("cleared", dma_ctrl_pkg::OFF_ENABLE_SET, 0);
	endtask

	task t_soft;
		setup(dma_ctrl_pkg::software_request_channel, 0, 3'h2, 2'h2, 2);
		wr(dma_ctrl_pkg::OFF_ENABLE_SET, 32'h4000_0000);
		wr(dma_ctrl_pkg::OFF_SW_REQ, 32'h4000_0000);
		wait_moves(2);
		chk("own line", swDone, 1);
		chk("no periph line", doneMask[30], 0);
	endtask

	task t_double;
		setup(5, 1, 3'h3, 2'h0, 2);
		setup(5, 0, 3'h3, 2'h0, 2);
		wr(dma_ctrl_pkg::OFF_ENABLE_SET, 32'h0000_0020);
		dCmd[5] <= 1;
		wait_moves(4);
		dCmd[5] <= 0;
		chk("alternate used", lastInfo, {1'b1, 5'h05, 2'h0});
		chk("done once", doneMask[5], 1);
		rdchk("index", dma_ctrl_pkg::OFF_STRUCT_INDEX, 32'h05);
		rdchk("idle halted", dma_ctrl_pkg::OFF_STRUCT_CTRL, 0);
		setup(6, 1, 3'h4, 2'h0, 3);
		rdchk("alt mem list", dma_ctrl_pkg::OFF_STRUCT_CTRL, 32'h0003_0005);
		setup(6, 0, 3'h7, 2'h0, 3);
		rdchk("pri periph list", dma_ctrl_pkg::OFF_STRUCT_CTRL, 32'h0003_0006);
	endtask

	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1;
		t_reset;
		t_basic;
		t_select;
		t_auto;
		t_soft;
		t_double;
		print_verdict;
	end
endmodule

`default_nettype wire
